//--- logic/logic_input_pkg.sv
// package: register map, field layout and timing for the logic input router
package logic_input_pkg;
    // register byte offsets
    localparam logic [11:0] DEST_BASE_OFFSET   = 12'h000; // input2..input10 destinations, one word each
    localparam logic [11:0] FIXED_DIS_OFFSET   = 12'h040; // fixed_function_disable
    localparam logic [11:0] INVERT_OFFSET      = 12'h044; // invert bits, bit0 = input2
    localparam logic [11:0] PERMIT_OFFSET      = 12'h048; // permits
    localparam logic [11:0] STATUS_OFFSET      = 12'h04C; // input status, read only
    localparam logic [11:0] CONTROL_OFFSET     = 12'h050; // serial-link control word
    localparam logic [11:0] ACTIVE_DEST_OFFSET = 12'h080; // active destinations base, read only
    // field positions
    localparam int PERMIT_INCH_REV_BIT = 0;
    localparam int PERMIT_INCH_FWD_BIT = 1;
    localparam int PERMIT_RUN_REV_BIT  = 2;
    localparam int PERMIT_RUN_FWD_BIT  = 3;
    localparam int STATUS_ENABLE_BIT   = 9;
    localparam int STATUS_FIRING_BIT   = 10;
    localparam int STATUS_REF_ON_BIT   = 11;
    localparam int CTRL_REF_ON_BIT     = 0;
    localparam int CTRL_REVERSE_BIT    = 1;
    localparam int CTRL_INCH_BIT       = 2;
    localparam int CTRL_RESET_BIT      = 8;
    // sizes and reset values
    localparam int NUM_PROG          = 9;
    localparam int DEST_W            = 11;
    localparam logic [10:0] DEST_MAX = 11'h7CF; // 1999
    localparam logic [10:0] DEST_RESET = 11'h000;
    localparam logic [8:0]  INVERT_RESET = 9'h000;
    localparam logic [3:0]  PERMIT_RESET = 4'h0;
    // destination parameter codes the router acts on
    localparam logic [10:0] DEST_REF_ON  = 11'h06F; // 111
    localparam logic [10:0] DEST_REVERSE = 11'h070; // 112
    localparam logic [10:0] DEST_INCH    = 11'h071; // 113
    // enable cutoff timing
    localparam int CLK_HZ          = 20000000;
    localparam int CUTOFF_MS       = 30;
    localparam int CUTOFF_CYCLES   = (CLK_HZ / 1000) * CUTOFF_MS;
    // drive command bundle
    typedef struct packed {
        logic ref_on;
        logic reverse;
        logic inch;
    } drive_cmd_t;
    // enable cutoff state
    typedef enum logic [1:0] {ST_OFF, ST_RUN, ST_CUTOFF} cut_state_t;
endpackage : logic_input_pkg

//--- logic/drive_logic_input_router.sv
// drive logic input router: terminal sampling, inversion, routing, enable cutoff
`timescale 1ns/1ps
// Function
// - status flag reads 1 when input active
// - firing cut thirty ms after enable loss
// - enable loss while running: coast, ramps reset
// - inputs two..ten have destination selector 0..1999
// - new destination applies only after drive reset
// - master bit: 0 fixed functions, 1 disabled
// - fixed: inch rev, inch fwd, run rev, fwd
// - programmed reference-on needs run-permit
// - serial link commands act when fixed disabled
// - inch reverse permit bit when fixed disabled
// - inch forward permit bit when fixed disabled
// - run reverse permit bit when fixed disabled
// - run forward permit bit when fixed disabled
// - fixed run inputs latch reference-on
module drive_logic_input_router
    import logic_input_pkg::*;
#(
    parameter int CUTOFF_COUNT = CUTOFF_CYCLES // 30 ms in clocks
)
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [NUM_PROG-1:0] logic_terminal_strip, // prog_input_two..ten, bit0 = two
    input  wire logic              enable_terminal,        // drive enable input
    input  wire logic              run_permit,             // start permit input
    input  wire logic              drive_running,          // drive currently running
    output logic                   firing_enable,          // firing pulses allowed
    output logic                   coast_stop,             // coast stop / ramps reset pulse
    output drive_cmd_t             drive_cmd               // routed commands to control
);
    // sampled terminals
    logic [NUM_PROG-1:0] term_reg;       // input stage
    logic                enable_reg;     // sampled enable
    logic                permit_reg;     // sampled run permit
    // software registers
    logic [DEST_W-1:0]   dest_reg   [NUM_PROG];  // written selectors
    logic [DEST_W-1:0]   active_reg [NUM_PROG];  // selectors in force
    logic                fixed_dis_reg;          // master bit
    logic [NUM_PROG-1:0] invert_reg;             // invert bits
    logic [3:0]          permit_bits_reg;        // function permits
    drive_cmd_t          serial_reg;             // link-written commands
    logic                ref_latch_reg;          // latched reference-on
    // cutoff timing
    cut_state_t          state_reg;
    cut_state_t          state_next;
    logic [31:0]         cut_cnt_reg;
    logic                coast_reg;

    // apb decode
    wire                 wr_en    = psel && penable && pwrite;
    wire                 rd_en    = psel && !pwrite;
    wire [9:0]           word     = paddr[11:2];
    wire                 hit_dest = (paddr < DEST_BASE_OFFSET + 12'(4*NUM_PROG));
    wire                 hit_act  = (paddr >= ACTIVE_DEST_OFFSET) &&
                                    (paddr < ACTIVE_DEST_OFFSET + 12'(4*NUM_PROG));
    wire [3:0]           dest_idx = 4'(word - DEST_BASE_OFFSET[11:2]);
    wire [3:0]           act_idx  = 4'(word - ACTIVE_DEST_OFFSET[11:2]);
    wire                 hit_ctl  = (paddr == FIXED_DIS_OFFSET) || (paddr == INVERT_OFFSET) ||
                                    (paddr == PERMIT_OFFSET) || (paddr == STATUS_OFFSET) ||
                                    (paddr == CONTROL_OFFSET);
    wire                 mapped   = (hit_dest || hit_act || hit_ctl) && (paddr[1:0] == 2'b00);
    // drive reset strobe applies selectors
    wire                 drive_reset = wr_en && (paddr == CONTROL_OFFSET) && pwdata[CTRL_RESET_BIT];

    // inverted inputs feed status and routing
    wire [NUM_PROG-1:0]  logic_in = term_reg ^ invert_reg;

    // programmed routing, or-reduced per destination
    logic                prog_ref_on;
    logic                prog_reverse;
    logic                prog_inch;
    always_comb
    begin
        prog_ref_on  = 1'b0;
        prog_reverse = 1'b0;
        prog_inch    = 1'b0;
        for (int i = 0; i < NUM_PROG; i++)
        begin
            prog_ref_on  = prog_ref_on  | (logic_in[i] && active_reg[i] == DEST_REF_ON);
            prog_reverse = prog_reverse | (logic_in[i] && active_reg[i] == DEST_REVERSE);
            prog_inch    = prog_inch    | (logic_in[i] && active_reg[i] == DEST_INCH);
        end
    end

    // fixed function decode: two inch rev, three inch fwd, four run rev, five run fwd
    wire fix_inch_rev = logic_in[0];
    wire fix_inch_fwd = logic_in[1];
    wire fix_run_rev  = logic_in[2];
    wire fix_run_fwd  = logic_in[3];
    // permitted functions when fixed functions are disabled
    wire dis_run_rev  = permit_bits_reg[PERMIT_RUN_REV_BIT]  && (prog_ref_on || serial_reg.ref_on) &&
                        (prog_reverse || serial_reg.reverse);
    wire dis_run_fwd  = permit_bits_reg[PERMIT_RUN_FWD_BIT]  && (prog_ref_on || serial_reg.ref_on) &&
                        !(prog_reverse || serial_reg.reverse);
    wire dis_inch_rev = permit_bits_reg[PERMIT_INCH_REV_BIT] && (prog_inch || serial_reg.inch) &&
                        (prog_reverse || serial_reg.reverse);
    wire dis_inch_fwd = permit_bits_reg[PERMIT_INCH_FWD_BIT] && (prog_inch || serial_reg.inch) &&
                        !(prog_reverse || serial_reg.reverse);
    // reference-on from a programmed terminal only with run permit; fixed run inputs drive it without permit
    wire prog_ref_ok  = prog_ref_on && permit_reg;

    // next command, selected by the master bit
    drive_cmd_t cmd_next;
    always_comb
    begin
        if (!fixed_dis_reg)
        begin
            cmd_next.ref_on  = (ref_latch_reg || fix_run_rev || fix_run_fwd) && enable_reg;
            cmd_next.reverse = fix_run_rev || fix_inch_rev;
            cmd_next.inch    = fix_inch_rev || fix_inch_fwd;
        end
        else
        begin
            cmd_next.ref_on  = (prog_ref_ok || serial_reg.ref_on) && (dis_run_rev || dis_run_fwd)
                               && enable_reg;
            cmd_next.reverse = dis_run_rev || dis_inch_rev;
            cmd_next.inch    = dis_inch_rev || dis_inch_fwd;
        end
    end

    // input sampling stage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            term_reg   <= '0;
            enable_reg <= 1'b0;
            permit_reg <= 1'b0;
        end
        else
        begin
            term_reg   <= logic_terminal_strip;
            enable_reg <= enable_terminal;
            permit_reg <= run_permit;
        end
    end

    // destination selectors: written copy and active copy
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < NUM_PROG; i++)
            begin
                dest_reg[i]   <= DEST_RESET;
                active_reg[i] <= DEST_RESET;
            end
        end
        else
        begin
            // writes above the range or off a word boundary are refused, the old value stays
            if (wr_en && hit_dest && mapped && pwdata[DEST_W-1:0] <= DEST_MAX && pwdata[31:DEST_W] == '0)
                dest_reg[dest_idx] <= pwdata[DEST_W-1:0];
            if (drive_reset)
                for (int i = 0; i < NUM_PROG; i++)
                    active_reg[i] <= dest_reg[i];
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fixed_dis_reg   <= 1'b0;
            invert_reg      <= INVERT_RESET;
            permit_bits_reg <= PERMIT_RESET;
            serial_reg      <= '0;
        end
        else if (wr_en)
        begin
            if (paddr == FIXED_DIS_OFFSET)
                fixed_dis_reg <= pwdata[0];
            if (paddr == INVERT_OFFSET)
                invert_reg <= pwdata[NUM_PROG-1:0];
            if (paddr == PERMIT_OFFSET)
                permit_bits_reg <= pwdata[3:0];
            if (paddr == CONTROL_OFFSET)
            begin
                serial_reg.ref_on  <= pwdata[CTRL_REF_ON_BIT];
                serial_reg.reverse <= pwdata[CTRL_REVERSE_BIT];
                serial_reg.inch    <= pwdata[CTRL_INCH_BIT];
            end
        end
    end

    // run latch: set by run inputs, cleared by enable loss, run permit loss or fixed functions disabled
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ref_latch_reg <= 1'b0;
        else if (fixed_dis_reg || !enable_reg || !permit_reg)
            ref_latch_reg <= 1'b0; // start permit drop stops latched run
        else if (fix_run_rev || fix_run_fwd)
            ref_latch_reg <= 1'b1;
    end

    // cutoff state machine
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_OFF:    if (enable_reg) state_next = ST_RUN;
            ST_RUN:    if (!enable_reg) state_next = ST_CUTOFF;
            ST_CUTOFF:
            begin
                if (enable_reg)
                    state_next = ST_RUN;
                else if (cut_cnt_reg >= 32'(CUTOFF_COUNT - 1))
                    state_next = ST_OFF;
            end
            default:   state_next = ST_OFF;
        endcase
    end

    // cutoff counter, coast pulse and command register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg   <= ST_OFF;
            cut_cnt_reg <= '0;
            coast_reg   <= 1'b0;
            drive_cmd   <= '0;
        end
        else
        begin
            state_reg   <= state_next;
            cut_cnt_reg <= (state_reg == ST_CUTOFF) ? cut_cnt_reg + 32'd1 : 32'd0;
            // loss of enable while running: coast stop and ramps reset
            coast_reg   <= (state_reg == ST_RUN) && !enable_reg && drive_running;
            drive_cmd   <= cmd_next;
        end
    end

    assign firing_enable = (state_reg != ST_OFF);
    assign coast_stop    = coast_reg;

    // read mux
    logic [31:0] rd_data;
    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (hit_dest)
            rd_data = {21'h0, dest_reg[dest_idx]};
        else if (hit_act)
            rd_data = {21'h0, active_reg[act_idx]};
        else if (paddr == FIXED_DIS_OFFSET)
            rd_data = {31'h0, fixed_dis_reg};
        else if (paddr == INVERT_OFFSET)
            rd_data = {23'h0, invert_reg};
        else if (paddr == PERMIT_OFFSET)
            rd_data = {28'h0, permit_bits_reg};
        else if (paddr == STATUS_OFFSET)
            rd_data = {20'h0, drive_cmd.ref_on, firing_enable, enable_reg, logic_in};
        else if (paddr == CONTROL_OFFSET)
            rd_data = {29'h0, serial_reg.inch, serial_reg.reverse, serial_reg.ref_on};
    end

    // read data registered in setup cycle, zero-wait slave
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en && !penable)
            prdata <= rd_data;
    end

    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
endmodule : drive_logic_input_router

//--- verification/terminal_switches.sv
// partner model: switches and controllers wired to the logic terminals
`timescale 1ns/1ps
module terminal_switches
    import logic_input_pkg::*;
(
    input  wire logic                pclk,
    input  wire logic [NUM_PROG-1:0] sw_strip,             // requested contact states
    input  wire logic                sw_enable,            // requested enable contact
    input  wire logic                sw_permit,            // requested run permit
    input  wire logic                sw_running,           // requested running flag
    output logic      [NUM_PROG-1:0] logic_terminal_strip, // terminal levels
    output logic                     enable_terminal,
    output logic                     run_permit,
    output logic                     drive_running
);
    // quiet contacts at power up so no input floats
    initial
    begin
        {logic_terminal_strip, enable_terminal, run_permit, drive_running} = '0;
    end
    // contacts follow one clock late, like a relay that is never instant
    always @(posedge pclk)
    begin
        {logic_terminal_strip, enable_terminal, run_permit, drive_running} <=
            {sw_strip, sw_enable, sw_permit, sw_running};
    end
endmodule : terminal_switches

//--- verification/drive_logic_input_router_asserts.sv
// checker: port-level assertions for the logic input router
`timescale 1ns/1ps
module drive_logic_input_router_asserts
    import logic_input_pkg::*;
#(
    parameter int CUTOFF_COUNT = CUTOFF_CYCLES // cutoff delay in clocks
)
(
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [11:0]         paddr,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire logic [NUM_PROG-1:0] logic_terminal_strip,
    input wire logic                enable_terminal,
    input wire logic                run_permit,
    input wire logic                drive_running,
    input wire logic                firing_enable,
    input wire logic                coast_stop,
    input wire drive_cmd_t          drive_cmd
);
    localparam int CUT_HI = CUTOFF_COUNT + 4; // margin for sync and state latency
    logic [31:0] low_cnt_reg;                 // clocks since enable went low
    logic [31:0] low_cnt_next;
    logic        rd_acc;                      // read access phase
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign rd_acc = psel && penable && !pwrite;
    // saturate so the counter never wraps back into the window
    assign low_cnt_next = enable_terminal ? 32'h0 : ((low_cnt_reg < CUT_HI) ? low_cnt_reg + 32'h1 : low_cnt_reg);
    // counter of enable-low clocks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_cnt_reg <= 32'h0;
        else
            low_cnt_reg <= low_cnt_next;
    end
    sequence enable_loss;
        $fell(enable_terminal) && firing_enable;
    endsequence
    sequence strip_step;
        (!psel && $stable(enable_terminal) && $stable(run_permit) && $stable(logic_terminal_strip))
            ##1 (!psel && $changed(logic_terminal_strip));
    endsequence
    firing_on_a: assert property (enable_terminal [*4] |-> firing_enable)
        else $error("firing off while enabled");
    firing_hold_a: assert property (enable_loss |=> firing_enable [*8])
        else $error("firing cut too early");
    cutoff_end_a: assert property (low_cnt_reg == CUT_HI |-> !firing_enable)
        else $error("firing still on after cutoff");
    coast_fire_a: assert property (enable_loss ##0 drive_running |-> ##[1:3] coast_stop)
        else $error("no coast stop on enable loss");
    coast_pulse_a: assert property (coast_stop |=> !coast_stop)
        else $error("coast stop longer than one clock");
    input_sync_a: assert property (strip_step |=> $stable(drive_cmd))
        else $error("command reacted before input sampling");
    dest_range_a: assert property (rd_acc && paddr[1:0] == 2'h0 && (paddr <= 12'h020 ||
        (paddr >= ACTIVE_DEST_OFFSET && paddr <= 12'h0A0)) |-> prdata <= {21'h0, DEST_MAX})
        else $error("destination out of range");
    unmapped_err_a: assert property (psel && penable && paddr == 12'h0F0 |-> pslverr && pready)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (rd_acc && paddr == STATUS_OFFSET |-> !pslverr && pready)
        else $error("status read refused");
endmodule : drive_logic_input_router_asserts
bind drive_logic_input_router drive_logic_input_router_asserts #(.CUTOFF_COUNT(CUTOFF_COUNT)) u_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .logic_terminal_strip(logic_terminal_strip),
    .enable_terminal(enable_terminal), .run_permit(run_permit), .drive_running(drive_running),
    .firing_enable(firing_enable), .coast_stop(coast_stop), .drive_cmd(drive_cmd));

//--- verification/tb.sv
// testbench: registers, status, routing, fixed functions and enable cutoff
`timescale 1ns/1ps
module tb import logic_input_pkg::*;;
    localparam int CUT = 20;                  // shortened cutoff for simulation
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, firing_enable, coast_stop, cs;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [8:0]  sw_strip, strip, inv;
    logic [3:0]  pm;                          // random function permits
    logic        sw_enable, sw_permit, sw_running, enable_terminal, run_permit, drive_running;
    logic [10:0] dq [9];                      // destinations written per input
    drive_cmd_t  drive_cmd;
    int          n_errors = 0, samples_checked = 0, cyc = 0, seed = 29, k, t;
    // free-running bus clock
    initial
    begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end
    drive_logic_input_router #(.CUTOFF_COUNT(CUT)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .logic_terminal_strip(strip), .enable_terminal(enable_terminal),
        .run_permit(run_permit), .drive_running(drive_running), .firing_enable(firing_enable),
        .coast_stop(coast_stop), .drive_cmd(drive_cmd));
    terminal_switches u_sw (.pclk(pclk), .sw_strip(sw_strip), .sw_enable(sw_enable), .sw_permit(sw_permit),
        .sw_running(sw_running), .logic_terminal_strip(strip), .enable_terminal(enable_terminal),
        .run_permit(run_permit), .drive_running(drive_running));
    // expected status: enable flag above inverted inputs
    function automatic logic [31:0] stat_exp(input logic en, input logic [8:0] s, input logic [8:0] i);
        return {22'h0, en, s ^ i};
    endfunction : stat_exp
    // expected command from permit bits and a serial control word
    function automatic logic [31:0] cmd_exp(input logic [3:0] p, input logic [2:0] w);
        logic rr, rf, ir, ifw;
        rr  = p[PERMIT_RUN_REV_BIT] & w[CTRL_REF_ON_BIT] & w[CTRL_REVERSE_BIT];
        rf  = p[PERMIT_RUN_FWD_BIT] & w[CTRL_REF_ON_BIT] & ~w[CTRL_REVERSE_BIT];
        ir  = p[PERMIT_INCH_REV_BIT] & w[CTRL_INCH_BIT] & w[CTRL_REVERSE_BIT];
        ifw = p[PERMIT_INCH_FWD_BIT] & w[CTRL_INCH_BIT] & ~w[CTRL_REVERSE_BIT];
        return {29'h0, rr | rf, rr | ir, ir | ifw};
    endfunction : cmd_exp
    task automatic end_sim();
        if (n_errors == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e)
        begin
            n_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // one apb transfer; request held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        @(posedge pclk);
        while (pready !== 1'h1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask : apb
    // partner delay plus two sampling stages
    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask : settle
    // hang guard, well above the expected few hundred clocks
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_errors++;
            end_sim();
        end
    end
    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {sw_strip, sw_enable, sw_permit, sw_running} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (k = 0; k < 9; k++)
        begin
            apb(1'h0, 12'(4 * k), 32'h0);
            chk("dest reset", 32'h0, rd);
        end
        apb(1'h0, FIXED_DIS_OFFSET, 32'h0);
        chk("mode reset", 32'h0, rd);
        apb(1'h0, PERMIT_OFFSET, 32'h0);
        chk("permit reset", 32'h0, rd);
        apb(1'h1, PERMIT_OFFSET, 32'hF);
        apb(1'h0, PERMIT_OFFSET, 32'h0);
        chk("permit rw", 32'hF, rd);
        apb(1'h1, PERMIT_OFFSET, 32'h0);
        apb(1'h0, 12'h0F0, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        // random inputs and invert masks seen in status
        sw_enable <= 1'h1;
        for (k = 0; k < 8; k++)
        begin
            inv = 9'($random(seed));
            apb(1'h1, INVERT_OFFSET, {23'h0, inv});
            sw_strip <= 9'($random(seed));
            settle();
            apb(1'h0, STATUS_OFFSET, 32'h0);
            chk("status", stat_exp(1'h1, sw_strip, inv), {22'h0, rd[9:0]});
        end
        apb(1'h1, INVERT_OFFSET, 32'h0);
        // fixed functions, run inputs latch reference on
        sw_permit <= 1'h1;
        sw_strip <= 9'h008;
        settle();
        chk("run fwd", 32'h4, {29'h0, drive_cmd});
        sw_strip <= 9'h000;
        settle();
        chk("run latch", 32'h4, {29'h0, drive_cmd});
        sw_strip <= 9'h004;
        settle();
        chk("run rev", 32'h6, {29'h0, drive_cmd});
        sw_permit <= 1'h0;
        sw_strip <= 9'h000;
        settle();
        sw_permit <= 1'h1;
        sw_strip <= 9'h002;
        settle();
        chk("inch fwd", 32'h1, {30'h0, drive_cmd.reverse, drive_cmd.inch});
        sw_strip <= 9'h001;
        settle();
        chk("inch rev", 32'h3, {30'h0, drive_cmd.reverse, drive_cmd.inch});
        // fixed functions off: run input ignored, serial link obeyed
        sw_strip <= 9'h008;
        apb(1'h1, FIXED_DIS_OFFSET, 32'h1);
        settle();
        chk("fwd ignored", 32'h0, {29'h0, drive_cmd});
        for (k = 0; k < 16; k++)
        begin
            pm = 4'($random(seed));
            apb(1'h1, PERMIT_OFFSET, {28'h0, pm});
            apb(1'h1, CONTROL_OFFSET, 32'(k % 8));
            settle();
            chk("serial cmd", cmd_exp(pm, 3'(k)), {29'h0, drive_cmd});
        end
        apb(1'h1, CONTROL_OFFSET, 32'h0);
        apb(1'h1, PERMIT_OFFSET, 32'hF);
        // input six routed to reference on, live only after drive reset
        apb(1'h1, 12'h010, {21'h0, DEST_REF_ON});
        sw_strip <= 9'h010;
        settle();
        chk("route before reset", 32'h0, {31'h0, drive_cmd.ref_on});
        apb(1'h1, CONTROL_OFFSET, 32'h100);
        settle();
        chk("route after reset", 32'h1, {31'h0, drive_cmd.ref_on});
        sw_permit <= 1'h0;
        settle();
        chk("route no permit", 32'h0, {31'h0, drive_cmd.ref_on});
        // enable loss while running: delayed cut and coast stop
        sw_strip <= 9'h000;
        sw_running <= 1'h1;
        settle();
        chk("firing on", 32'h1, {31'h0, firing_enable});
        sw_enable <= 1'h0;
        t = 0;
        cs = 1'h0;
        @(posedge pclk);
        while (firing_enable === 1'h1 && t < 100)
        begin
            cs = cs | (coast_stop === 1'h1);
            @(posedge pclk);
            t++;
        end
        chk("cutoff window", 32'h1, {31'h0, t >= CUT && t <= CUT + 5});
        chk("coast stop", 32'h1, {31'h0, cs});
        // random selectors, illegal values dropped, applied at reset
        for (k = 0; k < 9; k++)
        begin
            dq[k] = 11'({$random(seed)} % 2000);
            apb(1'h1, 12'(4 * k), {21'h0, dq[k]});
            apb(1'h1, 12'(4 * k), 32'h7D0 + 32'(k));
            apb(1'h0, 12'(4 * k), 32'h0);
            chk("dest rw", {21'h0, dq[k]}, rd);
        end
        apb(1'h1, CONTROL_OFFSET, 32'h100);
        for (k = 0; k < 9; k++)
        begin
            apb(1'h0, ACTIVE_DEST_OFFSET + 12'(4 * k), 32'h0);
            chk("active dest", {21'h0, dq[k]}, rd);
        end
        end_sim();
    end
endmodule : tb
